// [logic/tcc_map.svh]
// register map, field positions and reset values of the timer capture compare unit
// assumes a 32-bit apb slave where each register index sits at byte address 4 * index
//
// Notes on behaviour
// - rising external edge is a capture event when its enable is set
// - falling external edge is a capture event when its enable is set
// - writing one to soft capture r stores the count into capture r; self clears
// - writing one to soft capture f makes a capture event; bit self clears
// - external, encoder and software capture sources may all be enabled together
// - period written high byte then low; low byte write takes the value
// - reading either period byte returns the live counter byte
// - compare written high then low; low write takes it; reads give stored bytes
// - capture r holds the count of the last r capture; writes ignored
// - terminal and compare flags set by hardware, cleared by writing zero
// - counter reset clears count, sets outputs to their inactive polarity level and stops the counter
// - live index and phase levels readable; two output polarity bits
// - enables gate terminal and compare interrupts and encoder capture source
// - clear on capture restarts the count from zero after each capture
// - count up from zero each tick; reload to zero when count equals period
// - compare condition whenever the count matches the compare value while the run bit is set
// - new period and compare values become active when the period ends
// - run bit zero pauses counting, one resumes from the held value
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// ****************************************************************
// register indices
// ****************************************************************
`define TCC_IDX_CS        16'ha051
`define TCC_IDX_CFG       16'ha052
`define TCC_IDX_PRD_LO    16'ha054
`define TCC_IDX_PRD_HI    16'ha055
`define TCC_IDX_CMP_LO    16'ha056
`define TCC_IDX_CMP_HI    16'ha057
`define TCC_IDX_CAP_LO    16'ha060
`define TCC_IDX_CAP_HI    16'ha061
`define TCC_IDX_RUN       16'ha040
`define TCC_IDX_ISTAT     16'ha044
`define TCC_IDX_IMASK     16'ha045

// ****************************************************************
// decoder select positions
// ****************************************************************
`define TCC_NSEL          11
`define TCC_SEL_CS        0
`define TCC_SEL_CFG       1
`define TCC_SEL_PRD_LO    2
`define TCC_SEL_PRD_HI    3
`define TCC_SEL_CMP_LO    4
`define TCC_SEL_CMP_HI    5
`define TCC_SEL_CAP_LO    6
`define TCC_SEL_CAP_HI    7
`define TCC_SEL_RUN       8
`define TCC_SEL_ISTAT     9
`define TCC_SEL_IMASK     10

// ****************************************************************
// field positions
// ****************************************************************
`define TCC_CS_RST        7
`define TCC_CS_IDX        6
`define TCC_CS_PA         5
`define TCC_CS_PB         4
`define TCC_CS_TMPOL      3
`define TCC_CS_CMPOL      2
`define TCC_CS_TMF        1
`define TCC_CS_CMF        0
`define TCC_CFG_IENTM     7
`define TCC_CFG_IENCM     6
`define TCC_CFG_ENC       5
`define TCC_CFG_CLR       4
`define TCC_CFG_XR        3
`define TCC_CFG_XF        2
`define TCC_CFG_SWR       1
`define TCC_CFG_SWF       0
`define TCC_RUN_BIT       0
`define TCC_IRQ_TM        0
`define TCC_IRQ_CM        1
`define TCC_IRQ_CAP       2

// ****************************************************************
// synchroniser lanes and reset values
// ****************************************************************
`define TCC_LN_EXT        0
`define TCC_LN_IDX        1
`define TCC_LN_PA         2
`define TCC_LN_PB         3
`define TCC_RST_BYTE      8'h00
`define TCC_RST_WORD      16'h0000

`endif

// [logic/tcc_pkg.sv]
// types of the timer capture compare unit
// assumes tcc_map.svh supplies the numeric constants
package tcc_pkg;

    typedef struct packed {
        logic        run;
        logic [15:0] pre_cnt;
        logic [15:0] count;
        logic [15:0] period_act;
        logic [15:0] period_shd;
        logic [7:0]  period_hold;
        logic [15:0] cmp_act;
        logic [15:0] cmp_shd;
        logic [7:0]  cmp_hold;
        logic [15:0] capture_r;
        logic        tm_pol;
        logic        cm_pol;
        logic        tm_flag;
        logic        cm_flag;
        logic        ien_tm;
        logic        ien_cm;
        logic        enc_en;
        logic        clr_cap;
        logic        rise_en;
        logic        fall_en;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic        tm_out;
        logic        cm_out;
        logic        irq;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } tcc_state_type;

endpackage

// [logic/tcc_sync.sv]
// two flop synchroniser with edge detection for pin inputs
// assumes asynchronous pins; edges come from the second and third stage only
`timescale 1ns/1ps
module tcc_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
    } tcc_sync_state_type;

    tcc_sync_state_type state_r;
    tcc_sync_state_type state_nxt;

    always_comb begin
        state_nxt    = state_r;
        state_nxt.s1 = din;
        state_nxt.s2 = state_r.s1;
        state_nxt.s3 = state_r.s2;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign level = state_r.s2;
    assign rise  = state_r.s2 & ~state_r.s3;
    assign fall  = ~state_r.s2 & state_r.s3;

endmodule

// [logic/tcc_timer.sv]
// 16-bit timer with period, compare and capture r behind an apb slave
// assumes pins are asynchronous; encoder_event is a one-cycle pulse on pclk
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "tcc_map.svh"
module tcc_timer #(
    parameter int          ADDR_W   = 18,
    parameter logic [15:0] PRESCALE = 16'h0001
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              ext_capture_in,
    input  wire logic              index_input,
    input  wire logic              phase_a_input,
    input  wire logic              phase_b_input,
    input  wire logic              encoder_event,
    output logic                   terminal_out,
    output logic                   compare_out,
    output logic                   irq
);
    import tcc_pkg::*;

    // ****************************************************************
    // address decode
    // ****************************************************************
    function automatic logic [`TCC_NSEL-1:0] tcc_decode(input logic [ADDR_W-1:0] a);
        logic [15:0]           idx;
        logic [`TCC_NSEL-1:0]  sel;
        idx = 16'(a[ADDR_W-1:2]);
        sel = '0;
        if (a[1:0] == 2'b00) begin
            case (idx)
                `TCC_IDX_CS: begin
                    sel[`TCC_SEL_CS] = 1'b1;
                end
                `TCC_IDX_CFG: begin
                    sel[`TCC_SEL_CFG] = 1'b1;
                end
                `TCC_IDX_PRD_LO: begin
                    sel[`TCC_SEL_PRD_LO] = 1'b1;
                end
                `TCC_IDX_PRD_HI: begin
                    sel[`TCC_SEL_PRD_HI] = 1'b1;
                end
                `TCC_IDX_CMP_LO: begin
                    sel[`TCC_SEL_CMP_LO] = 1'b1;
                end
                `TCC_IDX_CMP_HI: begin
                    sel[`TCC_SEL_CMP_HI] = 1'b1;
                end
                `TCC_IDX_CAP_LO: begin
                    sel[`TCC_SEL_CAP_LO] = 1'b1;
                end
                `TCC_IDX_CAP_HI: begin
                    sel[`TCC_SEL_CAP_HI] = 1'b1;
                end
                `TCC_IDX_RUN: begin
                    sel[`TCC_SEL_RUN] = 1'b1;
                end
                `TCC_IDX_ISTAT: begin
                    sel[`TCC_SEL_ISTAT] = 1'b1;
                end
                `TCC_IDX_IMASK: begin
                    sel[`TCC_SEL_IMASK] = 1'b1;
                end
                default: begin
                    sel = '0;
                end
            endcase
        end
        return sel;
    endfunction

    // ****************************************************************
    // signals
    // ****************************************************************
    tcc_state_type        state_r;
    tcc_state_type        state_nxt;
    logic [3:0]           pin_level;
    logic [3:0]           pin_rise;
    logic [3:0]           pin_fall;
    logic [`TCC_NSEL-1:0] sel;
    logic                 wr;
    logic [7:0]           wb;
    logic [7:0]           rd_byte;
    logic                 tick;
    logic                 tm_hit;
    logic                 cm_hit;
    logic                 soft_r;
    logic                 soft_f;
    logic                 cap_r;
    logic                 cap_any;
    logic                 rst_wr;
    logic [2:0]           irq_clr;
    logic [2:0]           irq_set;
    logic [2:0]           irq_gate;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    tcc_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .din   ({phase_b_input, phase_a_input, index_input, ext_capture_in}),
        .level (pin_level),
        .rise  (pin_rise),
        .fall  (pin_fall)
    );

    // ****************************************************************
    // read mux
    // ****************************************************************
    always_comb begin
        sel     = tcc_decode(paddr);
        rd_byte = `TCC_RST_BYTE;
        if (sel[`TCC_SEL_CS]) begin
            rd_byte[`TCC_CS_IDX]   = pin_level[`TCC_LN_IDX];
            rd_byte[`TCC_CS_PA]    = pin_level[`TCC_LN_PA];
            rd_byte[`TCC_CS_PB]    = pin_level[`TCC_LN_PB];
            rd_byte[`TCC_CS_TMPOL] = state_r.tm_pol;
            rd_byte[`TCC_CS_CMPOL] = state_r.cm_pol;
            rd_byte[`TCC_CS_TMF]   = state_r.tm_flag;
            rd_byte[`TCC_CS_CMF]   = state_r.cm_flag;
        end

        if (sel[`TCC_SEL_CFG]) begin
            rd_byte[`TCC_CFG_IENTM] = state_r.ien_tm;
            rd_byte[`TCC_CFG_IENCM] = state_r.ien_cm;
            rd_byte[`TCC_CFG_ENC]   = state_r.enc_en;
            rd_byte[`TCC_CFG_CLR]   = state_r.clr_cap;
            rd_byte[`TCC_CFG_XR]    = state_r.rise_en;
            rd_byte[`TCC_CFG_XF]    = state_r.fall_en;
        end

        if (sel[`TCC_SEL_PRD_LO]) begin
            rd_byte = state_r.count[7:0];
        end

        if (sel[`TCC_SEL_PRD_HI]) begin
            rd_byte = state_r.count[15:8];
        end

        if (sel[`TCC_SEL_CMP_LO]) begin
            rd_byte = state_r.cmp_shd[7:0];
        end

        if (sel[`TCC_SEL_CMP_HI]) begin
            rd_byte = state_r.cmp_hold;
        end

        if (sel[`TCC_SEL_CAP_LO]) begin
            rd_byte = state_r.capture_r[7:0];
        end

        if (sel[`TCC_SEL_CAP_HI]) begin
            rd_byte = state_r.capture_r[15:8];
        end

        if (sel[`TCC_SEL_RUN]) begin
            rd_byte[`TCC_RUN_BIT] = state_r.run;
        end

        if (sel[`TCC_SEL_ISTAT]) begin
            rd_byte[2:0] = state_r.irq_stat;
        end

        if (sel[`TCC_SEL_IMASK]) begin
            rd_byte[2:0] = state_r.irq_mask;
        end
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        state_nxt = state_r;

        // write commits at the edge where pready is seen high
        wr = psel & penable & pwrite & state_r.pready & ~state_r.pslverr & pstrb[0];
        wb = pwdata[7:0];

        // one wait state: data and error are registered in the first access cycle
        state_nxt.pready  = 1'b0;
        state_nxt.pslverr = 1'b0;
        if (psel & penable & ~state_r.pready) begin
            state_nxt.pready  = 1'b1;
            state_nxt.pslverr = ~|sel;
            state_nxt.prdata  = {24'h000000, rd_byte};
        end

        // prescaled counting clock, only while running
        tick = 1'b0;
        if (state_r.run) begin
            if (state_r.pre_cnt >= PRESCALE - 16'h0001) begin
                state_nxt.pre_cnt = `TCC_RST_WORD;
                tick              = 1'b1;
            end else begin
                state_nxt.pre_cnt = state_r.pre_cnt + 16'h0001;
            end
        end

        tm_hit = tick & (state_r.count == state_r.period_act);
        cm_hit = tick & (state_r.count == state_r.cmp_act);

        // capture sources are independent and may coexist
        soft_r  = wr & sel[`TCC_SEL_CFG] & wb[`TCC_CFG_SWR];
        soft_f  = wr & sel[`TCC_SEL_CFG] & wb[`TCC_CFG_SWF];
        cap_r   = soft_r
                | (state_r.rise_en & pin_rise[`TCC_LN_EXT])
                | (state_r.fall_en & pin_fall[`TCC_LN_EXT])
                | (state_r.enc_en & encoder_event);
        cap_any = cap_r | soft_f;

        // counter
        if (tick) begin
            if (tm_hit) begin
                state_nxt.count = `TCC_RST_WORD;
            end else begin
                state_nxt.count = state_r.count + 16'h0001;
            end
        end

        if (tm_hit) begin
            state_nxt.period_act = state_r.period_shd;
            state_nxt.cmp_act    = state_r.cmp_shd;
        end

        if (cap_r) begin
            state_nxt.capture_r = state_r.count;
        end

        // a capture restart overrides the tick of the same cycle
        if (cap_any & state_r.clr_cap) begin
            state_nxt.count   = `TCC_RST_WORD;
            state_nxt.pre_cnt = `TCC_RST_WORD;
        end

        // control status writes
        rst_wr = wr & sel[`TCC_SEL_CS] & wb[`TCC_CS_RST];
        if (wr & sel[`TCC_SEL_CS]) begin
            state_nxt.tm_pol = wb[`TCC_CS_TMPOL];
            state_nxt.cm_pol = wb[`TCC_CS_CMPOL];
            if (!wb[`TCC_CS_TMF]) begin
                state_nxt.tm_flag = 1'b0;
            end
            if (!wb[`TCC_CS_CMF]) begin
                state_nxt.cm_flag = 1'b0;
            end
        end

        if (rst_wr) begin
            state_nxt.count   = `TCC_RST_WORD;
            state_nxt.pre_cnt = `TCC_RST_WORD;
            state_nxt.run     = 1'b0;
        end

        // configuration; soft capture bits are never stored, so they read back zero
        if (wr & sel[`TCC_SEL_CFG]) begin
            state_nxt.ien_tm  = wb[`TCC_CFG_IENTM];
            state_nxt.ien_cm  = wb[`TCC_CFG_IENCM];
            state_nxt.enc_en  = wb[`TCC_CFG_ENC];
            state_nxt.clr_cap = wb[`TCC_CFG_CLR];
            state_nxt.rise_en = wb[`TCC_CFG_XR];
            state_nxt.fall_en = wb[`TCC_CFG_XF];
        end

        // double buffered period and compare, taken on the low byte
        if (wr & sel[`TCC_SEL_PRD_HI]) begin
            state_nxt.period_hold = wb;
        end

        if (wr & sel[`TCC_SEL_PRD_LO]) begin
            state_nxt.period_shd = {state_r.period_hold, wb};
        end

        if (wr & sel[`TCC_SEL_CMP_HI]) begin
            state_nxt.cmp_hold = wb;
        end

        if (wr & sel[`TCC_SEL_CMP_LO]) begin
            state_nxt.cmp_shd = {state_r.cmp_hold, wb};
        end

        // run control
        if (wr & sel[`TCC_SEL_RUN]) begin
            state_nxt.run = wb[`TCC_RUN_BIT];
        end

        // sticky flags: a set in the clearing cycle survives
        state_nxt.tm_flag = state_nxt.tm_flag | tm_hit;
        state_nxt.cm_flag = state_nxt.cm_flag | cm_hit;

        // interrupt status, write one to clear, set wins
        irq_clr = (wr & sel[`TCC_SEL_ISTAT]) ? wb[2:0] : 3'h0;
        irq_set = 3'h0;
        irq_set[`TCC_IRQ_TM]  = tm_hit;
        irq_set[`TCC_IRQ_CM]  = cm_hit;
        irq_set[`TCC_IRQ_CAP] = cap_any;
        state_nxt.irq_stat = (state_r.irq_stat & ~irq_clr) | irq_set;
        if (wr & sel[`TCC_SEL_IMASK]) begin
            state_nxt.irq_mask = wb[2:0];
        end

        irq_gate = 3'h0;
        irq_gate[`TCC_IRQ_TM]  = state_nxt.ien_tm;
        irq_gate[`TCC_IRQ_CM]  = state_nxt.ien_cm;
        irq_gate[`TCC_IRQ_CAP] = 1'b1;
        state_nxt.irq = |(state_nxt.irq_stat & state_nxt.irq_mask & irq_gate);

        // outputs at the inactive level while stopped or being reset
        state_nxt.tm_out = (tm_hit & ~rst_wr) ^ state_nxt.tm_pol;
        state_nxt.cm_out = (state_nxt.run & (state_nxt.count == state_nxt.cmp_act))
                         ^ state_nxt.cm_pol;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign prdata       = state_r.prdata;
    assign pready       = state_r.pready;
    assign pslverr      = state_r.pslverr;
    assign terminal_out = state_r.tm_out;
    assign compare_out  = state_r.cm_out;
    assign irq          = state_r.irq;

endmodule

// [tb/tcc_pins.sv]
// model of the pins and encoder logic that feed the timer
// assumes the bench calls its tasks; levels change just after a rising pclk edge
`timescale 1ns/1ps
module tcc_pins (
    input  wire logic pclk,
    output logic      ext_capture_in,
    output logic      index_input,
    output logic      phase_a_input,
    output logic      phase_b_input,
    output logic      encoder_event
);
    initial begin
        ext_capture_in = 1'b0;
        index_input = 1'b0;
        phase_a_input = 1'b0;
        phase_b_input = 1'b0;
        encoder_event = 1'b0;
    end
    task automatic drive(input logic e, input logic i, input logic a, input logic b);
        @(posedge pclk);
        ext_capture_in <= e;
        index_input <= i;
        phase_a_input <= a;
        phase_b_input <= b;
    endtask
    // encoder event is one pclk wide
    task automatic enc_pulse;
        @(posedge pclk);
        encoder_event <= 1'b1;
        @(posedge pclk);
        encoder_event <= 1'b0;
    endtask
endmodule

// [tb/tcc_props.sv]
// concurrent checks on the timer's apb slave and its compare and terminal outputs
// assumes the tcc_map.svh register indices and a byte address of four times the index
`timescale 1ns/1ps
`include "tcc_map.svh"
module tcc_props #(
    parameter int ADDR_W = 18
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    input  wire logic              pslverr,
    input  wire logic              terminal_out,
    input  wire logic              compare_out
);
    // ****
    // helpers
    // ****
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic done;
    logic mapped;
    assign done = psel && penable && pready;
    assign mapped = paddr[1:0] == 2'b00 && paddr[ADDR_W-1:2] inside {`TCC_IDX_CS, `TCC_IDX_CFG,
        `TCC_IDX_PRD_LO, `TCC_IDX_PRD_HI, `TCC_IDX_CMP_LO, `TCC_IDX_CMP_HI, `TCC_IDX_CAP_LO,
        `TCC_IDX_CAP_HI, `TCC_IDX_RUN, `TCC_IDX_ISTAT, `TCC_IDX_IMASK};
    sequence cs_rst_done;
        done && pwrite && pstrb[0] && paddr[ADDR_W-1:2] == `TCC_IDX_CS && pwdata[7]
            && !pwdata[3] && !pwdata[2];
    endsequence
    sequence pause_done;
        done && pwrite && pstrb[0] && paddr[ADDR_W-1:2] == `TCC_IDX_RUN && !pwdata[0];
    endsequence
    a_ready_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_map_err: assert property (done && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    a_map_ok: assert property (done && mapped |-> !pslverr)
        else $error("mapped access refused");
    a_read_narrow: assert property (done && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_refused_zero: assert property (done && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read data not zero");
    a_reset_stops: assert property (cs_rst_done |=> (!terminal_out && !compare_out) [*4])
        else $error("outputs active after counter reset");
    a_pause_holds: assert property (pause_done |=> ##1 $stable(compare_out) [*3])
        else $error("compare output moves while paused");
endmodule

bind tcc_timer tcc_props #(.ADDR_W(ADDR_W)) i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .terminal_out(terminal_out), .compare_out(compare_out));

// [tb/tcc_timer_tb.sv]
// self-checking bench of the timer: apb register sequences with expected values
// assumes tcc_timer, tcc_pins and the bound checker; prescale of one
`timescale 1ns/1ps
`include "tcc_map.svh"
module tcc_timer_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_capture_in;
    logic        index_input;
    logic        phase_a_input;
    logic        phase_b_input;
    logic        encoder_event;
    logic        terminal_out;
    logic        compare_out;
    logic        irq;
    int          fail_count = 0;
    int          compares = 0;
    logic [7:0]  cnt;
    logic [7:0]  v;
    logic        e;
    logic [15:0] regs [8] = '{`TCC_IDX_CS, `TCC_IDX_CFG, `TCC_IDX_PRD_LO, `TCC_IDX_PRD_HI,
        `TCC_IDX_CMP_LO, `TCC_IDX_CMP_HI, `TCC_IDX_CAP_LO, `TCC_IDX_CAP_HI};
    logic [7:0]  ecfg [4] = '{8'hc8, 8'hc8, 8'hc4, 8'hc4};
    logic        elv [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic [7:0]  eexp [4] = '{8'h06, 8'h02, 8'h02, 8'h06};

    always #2.5 pclk = ~pclk;

    tcc_timer #(.PRESCALE(16'h0001)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_capture_in(ext_capture_in), .index_input(index_input),
        .phase_a_input(phase_a_input), .phase_b_input(phase_b_input),
        .encoder_event(encoder_event), .terminal_out(terminal_out),
        .compare_out(compare_out), .irq(irq));
    tcc_pins i_pins (
        .pclk(pclk), .ext_capture_in(ext_capture_in), .index_input(index_input),
        .phase_a_input(phase_a_input), .phase_b_input(phase_b_input),
        .encoder_event(encoder_event));

    // ****
    // access and compare tasks
    // ****
    task automatic apb(input logic w, input logic [15:0] ix, input logic [7:0] d,
                       output logic [7:0] q, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] ix, input logic [7:0] d);
        logic [7:0] q;
        logic er;
        apb(1'b1, ix, d, q, er);
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rd(input logic [15:0] ix, input logic [7:0] exp);
        logic [7:0] q;
        logic er;
        apb(1'b0, ix, 8'h00, q, er);
        chk($sformatf("reg %h", ix), exp, q);
    endtask
    task automatic conclude;
        if (fail_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        #60000;
        fail_count++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[i]) rd(regs[i], 8'h00);
        apb(1'b0, 16'ha050, 8'h00, v, e);
        chk("unmapped err", 8'h01, {7'h0, e});
        chk("unmapped data", 8'h00, v);
        wr(`TCC_IDX_CMP_HI, 8'h00);
        wr(`TCC_IDX_CMP_LO, 8'h10);
        wr(`TCC_IDX_PRD_HI, 8'h01);
        wr(`TCC_IDX_PRD_LO, 8'h00);
        wr(`TCC_IDX_CFG, 8'hc0);
        wr(`TCC_IDX_IMASK, 8'h01);
        wr(`TCC_IDX_RUN, 8'h01);
        repeat (60) @(posedge pclk);
        wr(`TCC_IDX_RUN, 8'h00);
        rd(`TCC_IDX_CS, 8'h03);
        rd(`TCC_IDX_PRD_HI, 8'h00);
        apb(1'b0, `TCC_IDX_PRD_LO, 8'h00, cnt, e);
        chk("count range", 8'h01, {7'h0, cnt > 8'h10});
        rd(`TCC_IDX_PRD_LO, cnt);
        rd(`TCC_IDX_CMP_LO, 8'h10);
        rd(`TCC_IDX_ISTAT, 8'h03);
        chk("irq set", 8'h01, {7'h0, irq});
        wr(`TCC_IDX_CMP_HI, 8'h5a);
        rd(`TCC_IDX_CMP_HI, 8'h5a);
        rd(`TCC_IDX_CMP_LO, 8'h10);
        wr(`TCC_IDX_IMASK, 8'h00);
        repeat (2) @(posedge pclk);
        chk("irq masked", 8'h00, {7'h0, irq});
        wr(`TCC_IDX_IMASK, 8'h01);
        wr(`TCC_IDX_ISTAT, 8'h01);
        rd(`TCC_IDX_ISTAT, 8'h02);
        chk("irq cleared", 8'h00, {7'h0, irq});
        wr(`TCC_IDX_CFG, 8'hc2);
        rd(`TCC_IDX_CAP_LO, cnt);
        rd(`TCC_IDX_CAP_HI, 8'h00);
        rd(`TCC_IDX_CFG, 8'hc0);
        wr(`TCC_IDX_CAP_LO, 8'hff);
        rd(`TCC_IDX_CAP_LO, cnt);
        wr(`TCC_IDX_ISTAT, 8'h04);
        for (int i = 0; i < 4; i++) begin
            wr(`TCC_IDX_CFG, ecfg[i]);
            i_pins.drive(elv[i], 1'b0, 1'b0, 1'b0);
            repeat (6) @(posedge pclk);
            rd(`TCC_IDX_ISTAT, eexp[i]);
            wr(`TCC_IDX_ISTAT, 8'h04);
        end
        wr(`TCC_IDX_CFG, 8'hf0);
        i_pins.enc_pulse();
        repeat (2) @(posedge pclk);
        rd(`TCC_IDX_CAP_LO, cnt);
        rd(`TCC_IDX_PRD_LO, 8'h00);
        wr(`TCC_IDX_ISTAT, 8'h04);
        wr(`TCC_IDX_CFG, 8'hc1);
        rd(`TCC_IDX_ISTAT, 8'h06);
        rd(`TCC_IDX_CFG, 8'hc0);
        i_pins.drive(1'b0, 1'b1, 1'b0, 1'b1);
        repeat (4) @(posedge pclk);
        wr(`TCC_IDX_CS, 8'h0f);
        rd(`TCC_IDX_CS, 8'h5f);
        chk("terminal idle", 8'h01, {7'h0, terminal_out});
        chk("compare idle", 8'h01, {7'h0, compare_out});
        wr(`TCC_IDX_CS, 8'h80);
        rd(`TCC_IDX_CS, 8'h50);
        rd(`TCC_IDX_PRD_LO, 8'h00);
        rd(`TCC_IDX_RUN, 8'h00);
        chk("outputs cleared", 8'h00, {6'h0, terminal_out, compare_out});
        conclude();
    end
endmodule
